// ==== hw/ufh_top.sv ====
// Serial transceiver core: register slave, framed transmitter and half-duplex routing
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`default_nettype none
module ufh_top (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_i,
	input wire logic tx_i,
	output logic tx_o,
	output logic tx_oe_n,
	output logic serial_clock_out_pin,
	output logic irq
);
	typedef struct packed {
		logic [8:0] ctrl1;
		logic [7:0] ctrl2;
		logic [2:0] ctrl3;
		logic [15:0] baud;
		logic pe;
		logic tc;
		logic txbe;
		logic rxne;
		logic [8:0] rxdata;
		logic [8:0] txbuf;
		ufh_pkg::ufh_tx_e tx_st;
		logic [8:0] sh;
		logic [3:0] bits;
		logic [5:0] tcnt;
		logic [15:0] div;
		logic tick;
		logic tx_o;
		logic tx_oe_n;
		logic ck;
		logic irq;
		logic aw_got;
		logic [5:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ufh_top_s;
	ufh_top_s s;
	ufh_top_s next_s;
	logic rx_line;
	logic rx_valid;
	logic [8:0] rx_data;
	logic rx_perr;
	logic rx_mute;
	logic [4:0] osr;
	logic [3:0] nbits;
	logic [5:0] stop_ticks;
	logic [8:0] frame;
	logic [32:0] rd;
	logic [31:0] wv;
	logic wr;
	logic last_tick;
	logic load;
	logic hd;

	// ----------------------------------------
	// Register helpers
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Returns {error, data} for a register offset
	function automatic logic [32:0] regval(input logic [5:0] a);
		logic [32:0] r;
		r = {1'b0, 32'h0};
		if (a == ufh_pkg::ADDR_CTRL1) begin
			r[8:0] = s.ctrl1;
		end else if (a == ufh_pkg::ADDR_CTRL2) begin
			r[7:0] = s.ctrl2;
		end else if (a == ufh_pkg::ADDR_CTRL3) begin
			r[2:0] = s.ctrl3;
		end else if (a == ufh_pkg::ADDR_BAUD) begin
			r[15:0] = s.baud;
		end else if (a == ufh_pkg::ADDR_STATUS) begin
			r[ufh_pkg::ST_PE] = s.pe;
			r[ufh_pkg::ST_TC] = s.tc;
			r[ufh_pkg::ST_TXBE] = s.txbe;
			r[ufh_pkg::ST_RXNE] = s.rxne;
			r[ufh_pkg::ST_MUTE] = rx_mute;
		end else if (a == ufh_pkg::ADDR_RXDATA) begin
			r[8:0] = s.rxdata;
		end else if (a == ufh_pkg::ADDR_FLAG_CLR || a == ufh_pkg::ADDR_TXDATA) begin
			r[32] = 1'b0;
		end else begin
			r[32] = 1'b1;
		end
		return r;
	endfunction

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	assign hd = s.ctrl3[ufh_pkg::C3_HD];
	// Rx pin is ignored in half-duplex; the shared tx wire feeds the receiver
	assign rx_line = hd ? tx_i : rx_i;

	ufh_rx u_rx (
		.clock(clock),
		.nrst(nrst),
		.tick(s.tick),
		.line(rx_line),
		.rx_en(s.ctrl1[ufh_pkg::C1_RXEN]),
		.osr8(s.ctrl1[ufh_pkg::C1_OS8]),
		.word_length_select(s.ctrl1[ufh_pkg::C1_WL]),
		.parity_enable(s.ctrl1[ufh_pkg::C1_PEN]),
		.parity_odd_select(s.ctrl1[ufh_pkg::C1_ODD]),
		.mp_en(s.ctrl1[ufh_pkg::C1_MP]),
		.own_addr(s.ctrl2[ufh_pkg::C2_ADDR +: 4]),
		.valid(rx_valid),
		.data(rx_data),
		.perr(rx_perr),
		.mute(rx_mute)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		osr = s.ctrl1[ufh_pkg::C1_OS8] ? ufh_pkg::OSR8 : ufh_pkg::OSR16;
		nbits = s.ctrl1[ufh_pkg::C1_WL] ? 4'h9 : 4'h8;
		if (s.ctrl2[ufh_pkg::C2_STOP +: 2] == ufh_pkg::STOP_ONE) begin
			stop_ticks = {1'b0, osr};
		end else if (s.ctrl2[ufh_pkg::C2_STOP +: 2] == ufh_pkg::STOP_ONE_HALF) begin
			stop_ticks = {1'b0, osr} + {2'h0, osr[4:1]};
		end else begin
			stop_ticks = {osr, 1'b0};
		end
		// Oversampling tick every baud+1 clocks
		next_s.tick = 1'b0;
		if (s.div >= s.baud) begin
			next_s.div = 16'h0000;
			next_s.tick = 1'b1;
		end else begin
			next_s.div = s.div + 16'h0001;
		end

		// Bus write: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		wr = s.aw_got && s.w_got && !s.bvalid;
		rd = regval(s.awaddr);
		wv = merge(rd[31:0], s.wdata, s.wstrb);
		if (wr) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = rd[32] ? ufh_pkg::RESP_SLVERR : ufh_pkg::RESP_OKAY;
			if (s.awaddr == ufh_pkg::ADDR_CTRL1) begin
				next_s.ctrl1 = wv[8:0];
			end else if (s.awaddr == ufh_pkg::ADDR_CTRL2) begin
				next_s.ctrl2 = wv[7:0];
			end else if (s.awaddr == ufh_pkg::ADDR_CTRL3) begin
				next_s.ctrl3 = wv[2:0];
			end else if (s.awaddr == ufh_pkg::ADDR_BAUD) begin
				next_s.baud = wv[15:0];
			end else if (s.awaddr == ufh_pkg::ADDR_FLAG_CLR) begin
				if (s.wstrb[0] && s.wdata[ufh_pkg::FC_PE]) begin
					next_s.pe = 1'b0;
				end
				if (s.wstrb[0] && s.wdata[ufh_pkg::FC_TC]) begin
					next_s.tc = 1'b0;
				end
			end else if (s.awaddr == ufh_pkg::ADDR_TXDATA) begin
				// A write while the buffer is full overwrites the pending word
				next_s.txbuf = wv[8:0];
				next_s.txbe = 1'b0;
				next_s.tc = 1'b0;
			end
		end

		// Bus read; reading received data frees its buffer
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rd = regval(s_axi_araddr);
			next_s.rvalid = 1'b1;
			next_s.rdata = rd[31:0];
			next_s.rresp = rd[32] ? ufh_pkg::RESP_SLVERR : ufh_pkg::RESP_OKAY;
			if (s_axi_araddr == ufh_pkg::ADDR_RXDATA) begin
				next_s.rxne = 1'b0;
			end
		end
		// Hardware sets come after clears so a coinciding event wins
		if (rx_valid) begin
			next_s.rxdata = rx_data;
			next_s.rxne = 1'b1;
			if (rx_perr) begin
				next_s.pe = 1'b1;
			end
		end

		// Frame build; parity sits in the top character bit
		frame = s.txbuf & (s.ctrl1[ufh_pkg::C1_WL] ? 9'h1ff : 9'h0ff);
		if (s.ctrl1[ufh_pkg::C1_PEN]) begin
			if (s.ctrl1[ufh_pkg::C1_WL]) begin
				frame[8] = (^s.txbuf[7:0]) ^ s.ctrl1[ufh_pkg::C1_ODD];
			end else begin
				frame[7] = (^s.txbuf[6:0]) ^ s.ctrl1[ufh_pkg::C1_ODD];
			end
		end

		// Transmitter, stepped on oversampling ticks
		last_tick = 1'b0;
		load = 1'b0;
		if (!s.ctrl1[ufh_pkg::C1_TRANSMITTER_ENABLE]) begin
			next_s.tx_st = ufh_pkg::TX_IDLE;
		end else if (s.tick) begin
			case (s.tx_st)
				ufh_pkg::TX_IDLE: begin
					load = !s.txbe;
				end
				ufh_pkg::TX_START: begin
					last_tick = s.tcnt == {1'b0, osr} - 6'h01;
					if (last_tick) begin
						next_s.tx_st = ufh_pkg::TX_DATA;
					end
				end
				ufh_pkg::TX_DATA: begin
					last_tick = s.tcnt == {1'b0, osr} - 6'h01;
					if (last_tick) begin
						next_s.sh = {1'b1, s.sh[8:1]};
						next_s.bits = s.bits + 4'h1;
						if (s.bits == nbits - 4'h1) begin
							next_s.tx_st = ufh_pkg::TX_STOP;
						end
					end
				end
				default: begin
					last_tick = s.tcnt == stop_ticks - 6'h01;
					if (last_tick) begin
						next_s.tx_st = ufh_pkg::TX_IDLE;
						if (s.txbe) begin
							next_s.tc = 1'b1;
						end else begin
							load = 1'b1;
						end
					end
				end
			endcase
			next_s.tcnt = last_tick ? 6'h00 : s.tcnt + 6'h01;
		end
		if (load) begin
			// Buffered word moves to the shifter; buffer free again
			next_s.sh = frame;
			// A word written in this very cycle stays pending for the next frame
			next_s.txbe = !(wr && s.awaddr == ufh_pkg::ADDR_TXDATA);
			next_s.bits = 4'h0;
			next_s.tcnt = 6'h00;
			next_s.tx_st = ufh_pkg::TX_START;
		end

		// Line level: low start, data, high stop and idle
		case (next_s.tx_st)
			ufh_pkg::TX_START: next_s.tx_o = 1'b0;
			ufh_pkg::TX_DATA: next_s.tx_o = next_s.sh[0];
			default: next_s.tx_o = 1'b1;
		endcase
		// Open drain in half-duplex: only ever pull low, release for high
		next_s.tx_oe_n = hd ? next_s.tx_o : 1'b0;
		if (hd) begin
			next_s.tx_o = 1'b0;
		end
		// Clock pulse in the second half of each data bit
		next_s.ck = s.ctrl2[ufh_pkg::C2_CKEN] && next_s.tx_st == ufh_pkg::TX_DATA
			&& next_s.tcnt >= {2'h0, osr[4:1]};
		next_s.irq = (next_s.pe && s.ctrl1[ufh_pkg::C1_PEIE])
			|| (next_s.tc && s.ctrl1[ufh_pkg::C1_TCIE]);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			s <= '0;
			s.ctrl1 <= ufh_pkg::CTRL1_RST;
			s.ctrl2 <= ufh_pkg::CTRL2_RST;
			s.ctrl3 <= ufh_pkg::CTRL3_RST;
			s.baud <= ufh_pkg::BAUD_RST;
			s.tc <= ufh_pkg::TC_RST;
			s.txbe <= ufh_pkg::TXBE_RST;
			s.tx_o <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// One write and one read in flight at a time
	assign s_axi_awready = !s.aw_got && !s.bvalid;
	assign s_axi_wready = !s.w_got && !s.bvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign tx_o = s.tx_o;
	assign tx_oe_n = s.tx_oe_n;
	assign serial_clock_out_pin = s.ck;
	assign irq = s.irq;
endmodule // ufh_top
`default_nettype wire

// ==== hw/ufh_pkg.sv ====
// Register map, field positions, reset values and state types of the serial transceiver
`default_nettype none
package ufh_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam int ADDR_W = 6;
	localparam logic [5:0] ADDR_CTRL1 = 6'h00;
	localparam logic [5:0] ADDR_CTRL2 = 6'h04;
	localparam logic [5:0] ADDR_CTRL3 = 6'h08;
	localparam logic [5:0] ADDR_BAUD = 6'h0c;
	localparam logic [5:0] ADDR_STATUS = 6'h10;
	localparam logic [5:0] ADDR_FLAG_CLR = 6'h14;
	localparam logic [5:0] ADDR_TXDATA = 6'h18;
	localparam logic [5:0] ADDR_RXDATA = 6'h1c;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int C1_TRANSMITTER_ENABLE = 0;
	localparam int C1_RXEN = 1;
	localparam int C1_WL = 2;
	localparam int C1_PEN = 3;
	localparam int C1_ODD = 4;
	localparam int C1_OS8 = 5;
	localparam int C1_MP = 6;
	localparam int C1_PEIE = 7;
	localparam int C1_TCIE = 8;
	localparam int C2_STOP = 0;
	localparam int C2_CKEN = 2;
	localparam int C2_LIN = 3;
	localparam int C2_ADDR = 4;
	localparam int C3_HD = 0;
	localparam int C3_IR = 1;
	localparam int C3_SC = 2;
	localparam int ST_PE = 0;
	localparam int ST_TC = 1;
	localparam int ST_TXBE = 2;
	localparam int ST_RXNE = 3;
	localparam int ST_MUTE = 4;
	localparam int FC_PE = 0;
	localparam int FC_TC = 1;
	// ----------------------------------------
	// Reset values and encodings
	// ----------------------------------------
	localparam logic [8:0] CTRL1_RST = 9'h000;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [2:0] CTRL3_RST = 3'h0;
	localparam logic [15:0] BAUD_RST = 16'h0001;
	localparam logic TC_RST = 1'b1;
	localparam logic TXBE_RST = 1'b1;
	localparam logic [1:0] STOP_ONE = 2'h0;
	localparam logic [1:0] STOP_ONE_HALF = 2'h1;
	localparam logic [4:0] OSR16 = 5'h10;
	localparam logic [4:0] OSR8 = 5'h08;
	localparam logic [7:0] IDLE_BITS = 8'h0a;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// State types
	// ----------------------------------------
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ufh_tx_e;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufh_rx_e;
endpackage
`default_nettype wire

// ==== hw/ufh_rx.sv ====
// Oversampling receiver with parity check and multiprocessor mute
`default_nettype none
module ufh_rx (
	input wire logic clock,
	input wire logic nrst,
	input wire logic tick,
	input wire logic line,
	input wire logic rx_en,
	input wire logic osr8,
	input wire logic word_length_select,
	input wire logic parity_enable,
	input wire logic parity_odd_select,
	input wire logic mp_en,
	input wire logic [3:0] own_addr,
	output logic valid,
	output logic [8:0] data,
	output logic perr,
	output logic mute
);
	typedef struct packed {
		ufh_pkg::ufh_rx_e st;
		logic [4:0] cnt;
		logic [3:0] bits;
		logic [8:0] sh;
		logic [7:0] idle;
		logic mute;
		logic valid;
		logic [8:0] data;
		logic perr;
	} ufh_rx_s;
	ufh_rx_s s;
	ufh_rx_s next_s;
	logic [4:0] osr;
	logic [3:0] nbits;
	logic [8:0] chr;
	logic [7:0] idle_lim;
	logic mute_n;

	// ----------------------------------------
	// Frame recovery
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.valid = 1'b0;
		next_s.perr = 1'b0;
		osr = osr8 ? ufh_pkg::OSR8 : ufh_pkg::OSR16;
		nbits = word_length_select ? 4'h9 : 4'h8;
		idle_lim = 8'(ufh_pkg::IDLE_BITS * {3'h0, osr}) - 8'h01;
		chr = word_length_select ? s.sh : {1'b0, s.sh[8:1]};
		mute_n = s.mute;
		if (!mp_en) begin
			next_s.mute = 1'b0;
		end
		if (!rx_en) begin
			next_s.st = ufh_pkg::RX_IDLE;
			next_s.cnt = 5'h00;
		end else if (tick) begin
			case (s.st)
				ufh_pkg::RX_IDLE: begin
					next_s.cnt = 5'h00;
					if (!line) begin
						next_s.st = ufh_pkg::RX_START;
						next_s.idle = 8'h00;
					end else if (s.idle >= idle_lim) begin
						next_s.mute = 1'b0;
					end else begin
						next_s.idle = s.idle + 8'h01;
					end
				end
				ufh_pkg::RX_START: begin
					if (s.cnt == (osr >> 1) - 5'h01) begin
						next_s.cnt = 5'h00;
						next_s.bits = 4'h0;
						next_s.st = line ? ufh_pkg::RX_IDLE : ufh_pkg::RX_DATA;
					end else begin
						next_s.cnt = s.cnt + 5'h01;
					end
				end
				ufh_pkg::RX_DATA: begin
					if (s.cnt == osr - 5'h01) begin
						next_s.cnt = 5'h00;
						next_s.sh = {line, s.sh[8:1]};
						next_s.bits = s.bits + 4'h1;
						if (s.bits == nbits - 4'h1) begin
							next_s.st = ufh_pkg::RX_STOP;
						end
					end else begin
						next_s.cnt = s.cnt + 5'h01;
					end
				end
				default: begin
					if (s.cnt == osr - 5'h01) begin
						next_s.st = ufh_pkg::RX_IDLE;
						next_s.cnt = 5'h00;
						// Address mark is the character's top bit
						if (mp_en && s.sh[8]) begin
							mute_n = chr[3:0] != own_addr;
						end
						next_s.mute = mp_en && mute_n;
						if (!next_s.mute) begin
							next_s.valid = 1'b1;
							next_s.data = chr;
							next_s.perr = parity_enable && ((^chr) ^ parity_odd_select);
						end
					end else begin
						next_s.cnt = s.cnt + 5'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign valid = s.valid;
	assign data = s.data;
	assign perr = s.perr;
	assign mute = s.mute;
endmodule // ufh_rx
`default_nettype wire

// ==== tb/ufh_monitor.sv ====
// Port checker of the serial transceiver
`default_nettype none
module ufh_monitor (
	input wire logic clock,
	input wire logic nrst,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic tx_o,
	input wire logic tx_oe_n,
	input wire logic serial_clock_out_pin
);
	logic txw;
	// Pull-up level of the pin as this end alone drives it
	assign txw = tx_oe_n | tx_o;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	property p_od; tx_oe_n |-> !tx_o; endproperty
	a_od: assert property (p_od) else $error("pin released while drive value high");
	property p_low; $fell(txw) |=> !txw [*7]; endproperty
	a_low: assert property (p_low) else $error("low level shorter than a bit");
	property p_high; $rose(txw) |=> txw [*7]; endproperty
	a_high: assert property (p_high) else $error("high level shorter than a bit");
	property p_ck; $rose(serial_clock_out_pin) |=> serial_clock_out_pin [*7]; endproperty
	a_ck: assert property (p_ck) else $error("clock pulse too short");
	property p_rst; $rose(nrst) |-> tx_o && !tx_oe_n && !serial_clock_out_pin; endproperty
	a_rst: assert property (p_rst) else $error("pin not idle after reset");
	property p_bw; $rose(s_axi_bvalid) && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
	a_bw: assert property (p_bw) else $error("write response not retired");
	property p_rv; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rv: assert property (p_rv) else $error("read address taken while answer pending");
	property p_rr; $rose(s_axi_rvalid) && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
	a_rr: assert property (p_rr) else $error("read answer not retired");
	c_ck: cover property ($rose(serial_clock_out_pin));
	c_hd: cover property ($fell(tx_oe_n));
	c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // ufh_monitor
`default_nettype wire

// ==== tb/ufh_partner.sv ====
// Behavioural far-side serial device: frame decoder and frame sender
`default_nettype none
module ufh_partner (
	input wire logic clock,
	input wire logic line,
	input wire logic [7:0] bit_clks,
	input wire logic [3:0] len,
	input wire logic go,
	input wire logic [11:0] word,
	output logic drive,
	output logic [11:0] seen,
	output logic [7:0] frames
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		drive = 1'b1;
		frames = 8'h00;
		seen = 12'hfff;
	end
	// Back to hunting at mid stop, so a back-to-back start is not missed
	always begin
		@(negedge line);
		seen = 12'hfff;
		repeat (bit_clks / 2) @(posedge clock);
		for (int i = 0; i < len; i++) begin
			if (i != 0) repeat (bit_clks) @(posedge clock);
			seen[i] = line;
		end
		frames = frames + 8'h01;
	end
	always @(posedge go) begin
		for (int i = 0; i < len; i++) begin
			drive <= word[i];
			repeat (bit_clks) @(posedge clock);
		end
		drive <= 1'b1;
	end
endmodule // ufh_partner
`default_nettype wire

// ==== tb/ufh_tb_top.sv ====
// Self-checking bench of the serial transceiver
`default_nettype none
module ufh_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] TXC [5] = '{12'h0d3, 12'h4d3, 12'h6d3, 12'h9d3, 12'hfd3};
	localparam logic [1:0] STP [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
	localparam int STX [4] = '{320, 336, 352, 160};
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [5:0] awaddr = 6'h00, araddr = 6'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, tx_o, tx_oe_n, ck, irq, txw, pdrv;
	logic hd = 1'b0, pgo = 1'b0, prev_w = 1'b1, prev_ck = 1'b0;
	logic [1:0] bresp, rresp;
	logic [7:0] pbits = 8'h20, pframes;
	logic [3:0] plen = 4'ha;
	logic [11:0] pword = 12'hfff, pseen;
	int err_count = 0, checks = 0, cyc = 0, last_fall = 0, gap = 0, ck_rises = 0;
	// Open-drain wire with pull-up in half-duplex; rx pin held low there to show it is ignored
	assign txw = (tx_oe_n | tx_o) & (hd ? pdrv : 1'b1);
	always #2.5 clock = ~clock;
	ufh_top i_ufh_top (.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_i(hd ? 1'b0 : pdrv),
		.tx_i(txw), .tx_o(tx_o), .tx_oe_n(tx_oe_n), .serial_clock_out_pin(ck), .irq(irq));
	ufh_partner i_ufh_partner (.clock(clock), .line(txw), .bit_clks(pbits), .len(plen), .go(pgo),
		.word(pword), .drive(pdrv), .seen(pseen), .frames(pframes));
	always @(posedge clock) begin
		cyc <= cyc + 1;
		prev_w <= txw;
		prev_ck <= ck;
		if (prev_w && !txw) begin
			gap <= cyc - last_fall;
			last_fall <= cyc;
		end
		if (!prev_ck && ck) ck_rises <= ck_rises + 1;
	end
	always @(posedge clock) begin
		if (cyc == 40000) begin
			err_count++;
			results();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("Counts: %0d checks, %0d mismatches", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		fork
			begin do @(posedge clock); while (!awready); awvalid <= 1'b0; end
			begin do @(posedge clock); while (!wready); wvalid <= 1'b0; end
		join
		do @(posedge clock); while (!bvalid);
		bready <= 1'b0;
		chk(32'(bresp), a > 6'h1f ? 32'h2 : 32'h0);
	endtask
	task rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clock); while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		chk(32'(rresp), a > 6'h1f ? 32'h2 : 32'h0);
	endtask
	task rdchk(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	task poll(input logic [31:0] m);
		logic [31:0] d;
		do rd(ufh_pkg::ADDR_STATUS, d); while ((d & m) == 32'h0);
	endtask
	function automatic logic [11:0] mk(input logic [8:0] d, input logic w, input logic p, input logic o);
		int n;
		mk = 12'hffe;
		n = w ? 9 : 8;
		for (int i = 0; i < n; i++) mk[i + 1] = d[i];
		if (p) mk[n] = ^(d & ((9'h1 << (n - 1)) - 9'h1)) ^ o;
	endfunction
	// Waits for the decoded frame and for transmit complete, so config changes never hit a frame
	task txf(input logic [8:0] d, input logic [11:0] e);
		logic [7:0] c;
		c = pframes;
		wr(ufh_pkg::ADDR_TXDATA, 32'(d));
		while (pframes == c) @(posedge clock);
		chk(32'(pseen), 32'(e));
		poll(32'h2);
	endtask
	task psend(input logic [7:0] d);
		// The sender ignores a start request until its previous stop bit is over
		repeat (pbits) @(posedge clock);
		pword <= {3'b111, d, 1'b0};
		pgo <= 1'b1;
		@(posedge clock);
		pgo <= 1'b0;
	endtask
	task t_reset;
		rdchk(ufh_pkg::ADDR_STATUS, 32'h6);
		rdchk(ufh_pkg::ADDR_CTRL2, 32'h0);
		rdchk(6'h20, 32'h0);
		chk(32'(txw), 32'h1);
		$display("test reset done");
	endtask
	task t_tx;
		logic [31:0] v;
		int c0;
		wr(ufh_pkg::ADDR_CTRL2, 32'h1 << ufh_pkg::C2_CKEN);
		for (int i = 0; i < 5; i++) begin
			v = 32'h1 << ufh_pkg::C1_TRANSMITTER_ENABLE;
			v[ufh_pkg::C1_WL] = TXC[i][11];
			v[ufh_pkg::C1_PEN] = TXC[i][10];
			v[ufh_pkg::C1_ODD] = TXC[i][9];
			wr(ufh_pkg::ADDR_CTRL1, v);
			plen <= TXC[i][11] ? 4'hb : 4'ha;
			c0 = ck_rises;
			txf(TXC[i][8:0], mk(TXC[i][8:0], TXC[i][11], TXC[i][10], TXC[i][9]));
			if (i == 0) chk(32'(ck_rises - c0), 32'h8);
		end
		wr(ufh_pkg::ADDR_CTRL2, 32'h0);
		$display("test framing done");
	endtask
	task t_stop;
		plen <= 4'ha;
		for (int i = 0; i < 4; i++) begin
			wr(ufh_pkg::ADDR_CTRL2, 32'(STP[i]));
			wr(ufh_pkg::ADDR_CTRL1, (i == 3 ? 32'h21 : 32'h1));
			pbits <= i == 3 ? 8'h10 : 8'h20;
			wr(ufh_pkg::ADDR_TXDATA, 32'hff);
			wr(ufh_pkg::ADDR_TXDATA, 32'hff);
			rdchk(ufh_pkg::ADDR_STATUS, 32'h0);
			poll(32'h2);
			chk(32'(gap), 32'(STX[i]));
		end
		wr(ufh_pkg::ADDR_CTRL1, 32'h101);
		@(posedge clock);
		chk(32'(irq), 32'h1);
		wr(ufh_pkg::ADDR_FLAG_CLR, 32'h2);
		@(posedge clock);
		chk(32'(irq), 32'h0);
		$display("test stop bits done");
	endtask
	task t_rx;
		logic [31:0] v;
		wr(ufh_pkg::ADDR_CTRL2, 32'h0);
		wr(ufh_pkg::ADDR_CTRL1, 32'h8a);
		pbits <= 8'h20;
		for (int k = 0; k < 2; k++) begin
			psend(k ? 8'h83 : 8'h03);
			poll(32'h8);
			rd(ufh_pkg::ADDR_STATUS, v);
			chk(v & 32'h1, 32'(k));
			chk(32'(irq), 32'(k));
			rdchk(ufh_pkg::ADDR_RXDATA, k ? 32'h83 : 32'h03);
		end
		wr(ufh_pkg::ADDR_FLAG_CLR, 32'h1);
		@(posedge clock);
		rd(ufh_pkg::ADDR_STATUS, v);
		chk(v & 32'h1, 32'h0);
		chk(32'(irq), 32'h0);
		// Own address 5: a foreign address mark mutes, a matching one wakes and is kept
		wr(ufh_pkg::ADDR_CTRL2, 32'h50);
		wr(ufh_pkg::ADDR_CTRL1, 32'h42);
		psend(8'h83);
		poll(32'h10);
		rdchk(ufh_pkg::ADDR_STATUS, 32'h14);
		psend(8'h85);
		poll(32'h8);
		rdchk(ufh_pkg::ADDR_STATUS, 32'hc);
		rdchk(ufh_pkg::ADDR_RXDATA, 32'h85);
		$display("test parity error done");
	endtask
	task t_hd;
		wr(ufh_pkg::ADDR_CTRL2, 32'h0);
		wr(ufh_pkg::ADDR_CTRL1, 32'h0);
		wr(ufh_pkg::ADDR_CTRL3, 32'h1);
		hd <= 1'b1;
		repeat (2) @(posedge clock);
		chk(32'(tx_oe_n), 32'h1);
		wr(ufh_pkg::ADDR_CTRL1, 32'h1);
		txf(9'h05a, mk(9'h05a, 1'b0, 1'b0, 1'b0));
		wr(ufh_pkg::ADDR_CTRL1, 32'h3);
		psend(8'h96);
		poll(32'h8);
		rdchk(ufh_pkg::ADDR_RXDATA, 32'h96);
		$display("test half-duplex done");
	endtask
	initial begin
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		t_reset();
		t_tx();
		t_stop();
		t_rx();
		t_hd();
		results();
	end
endmodule // ufh_tb_top
bind ufh_top ufh_monitor i_ufh_monitor (.clock(clock), .nrst(nrst), .s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp),
	.tx_o(tx_o), .tx_oe_n(tx_oe_n), .serial_clock_out_pin(serial_clock_out_pin));
`default_nettype wire
